// file: hw/pmonoff_pkg.sv
// package of the on/off and status command block: command codes,
// field positions, reset values and the carrier structs.
// assumes a command-code addressed port fed by the bus transport.
package pmonoff_pkg;

   // command codes
   localparam logic [7:0] CMD_OPERATION   = 8'h01;
   localparam logic [7:0] CMD_ONOFF_CFG   = 8'h02;
   localparam logic [7:0] CMD_CLEAR_FLT   = 8'h03;
   localparam logic [7:0] CMD_VOUT_FMT    = 8'h20;
   localparam logic [7:0] CMD_VOUT_SET    = 8'h21;
   localparam logic [7:0] CMD_STAT_BYTE   = 8'h78;
   localparam logic [7:0] CMD_STAT_WORD   = 8'h79;

   // operation register fields
   localparam int         OP_ACT_HI       = 7;
   localparam int         OP_ACT_LO       = 6;
   localparam int         OP_MRG_HI       = 5;
   localparam int         OP_MRG_LO       = 4;
   localparam logic [1:0] OP_ACT_SOFT_OFF = 2'h1;
   localparam logic [1:0] OP_ACT_ON       = 2'h2;
   localparam logic [1:0] OP_MRG_NONE     = 2'h0;

   // on/off configuration fields
   localparam int         CFG_OFF_MODE    = 0;
   localparam int         CFG_PIN_POL     = 1;
   localparam int         CFG_PIN_EN      = 2;
   localparam int         CFG_OP_EN       = 3;

   // output voltage format fields
   localparam int         FMT_EXP_HI      = 4;
   localparam logic [2:0] FMT_LINEAR      = 3'h0;

   // status word bit positions
   localparam int         SW_PGOOD_N      = 11;
   localparam int         SW_MFR          = 12;
   localparam int         SW_INPUT        = 13;
   localparam int         SW_IOUT         = 14;
   localparam int         SW_VOUT         = 15;

   // values after reset
   localparam logic [7:0]  OP_RESET       = 8'h40;
   localparam logic [7:0]  CFG_RESET      = 8'h0a;
   localparam logic [15:0] VSET_RESET     = 16'h0000;
   localparam logic [4:0]  VEXP_DEFAULT   = 5'h17;

   // fault and warning conditions, also the latched flags
   typedef struct packed {
      logic other;     // not covered by any summary bit
      logic cml;       // communication fault
      logic temp;      // temperature fault or warning
      logic vin_uv;    // input under-voltage fault
      logic iout_oc;   // output over-current fault
      logic vout_ov;   // output over-voltage fault
      logic mfr;       // maker-specific fault or warning
      logic input_any; // any input fault or warning
      logic iout_any;  // any output current/power fault or warning
      logic vout_any;  // any output voltage fault or warning
   } pmonoff_flt_t;

   // command request from the transport
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] wdata;
   } pmonoff_req_t;

   // answer to the transport
   typedef struct packed {
      logic        valid;
      logic        err;
      logic [15:0] rdata;
   } pmonoff_rsp_t;

   // whole module state
   typedef struct packed {
      logic [7:0]   op;
      logic [7:0]   cfg;
      logic [15:0]  vset;
      logic         op_on;
      pmonoff_flt_t flt;
      logic         latched_off;
      logic         alert;
      logic         ctl_meta;
      logic         ctl_sync;
      logic         unit_en;
      logic         off_seq;
      logic         pwr_off;
      logic         pgood_n;
      pmonoff_rsp_t rsp;
   } pmonoff_state_t;

endpackage : pmonoff_pkg

// file: hw/pmonoff_regs.sv
// on/off control, clear-faults handling and status summary registers.
// assumes command writes/reads arrive decoded by code from the transport,
// fault conditions and power state come from logic on sys_clk, the control
// pin comes from outside and is synchronised here.
//
// Summary of operation
// - operation 01 in top bits soft-off sequenced; 10 with 00 margin turns on.
// - commanded mode holds until new operation write; a control pin change leaves it.
// - config bit 0 ignored; turn-off always uses programmed delay and fall.
// - config bit 1 picks control pin polarity: 0 low starts, 1 high starts.
// - config bit 2 clear ignores pin; set requires pin asserted to start.
// - config bit 3 clear ignores operation; set requires operation on.
// - both requirements enabled means on only while both are on.
// - clear-faults clears every latched fault and warning status bit.
// - clear-faults releases the alert output if asserted.
// - after clear-faults unit resumes per configured on/off state.
// - faults still present at clear-faults set their bit again immediately.
// - format register read-only: exponent in bits 4:0, linear code 000 above.
// - 16-bit set-point mantissa writable at run time, scaled by exponent.
// - status byte bit 0 flags a fault not in bits 7 to 1.
// - status byte bit 1 flags a communication fault.
// - byte bit 2 temperature fault or warning; bit 3 input under-voltage.
// - byte bit 4 output over-current fault; bit 5 output over-voltage.
// - byte bit 6 set whenever unit is not delivering output power.
// - status word low byte equals the status byte.
// - status word bit 11 set while power-good is negated.
// - word bit 12 maker-specific fault or warning; bit 13 input related.
// - word bit 14 output current or power; bit 15 output voltage.
// - clear-faults is command code 03 with no data bytes.
`timescale 1ns/1ps
`default_nettype none

module pmonoff_regs #(
   parameter logic [4:0] VOUT_EXP = pmonoff_pkg::VEXP_DEFAULT  // exponent, two's complement
) (
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      arst_n,
   // command port from the transport
   input  wire pmonoff_pkg::pmonoff_req_t req,
   output var  pmonoff_pkg::pmonoff_rsp_t rsp,
   // control pin, asynchronous
   input  wire logic                      ctl_pin,
   // condition inputs from the converter logic
   input  wire pmonoff_pkg::pmonoff_flt_t flt_cond,
   input  wire logic                      fault_shutdown,
   input  wire logic                      pwr_active,
   input  wire logic                      pgood,
   // power stage control
   output logic                           unit_en,
   output logic                           off_seq,
   output logic [15:0]                    vout_mantissa,
   // alert, open drain
   output logic                           alert_o,
   output logic                           alert_oe
);

   pmonoff_pkg::pmonoff_state_t st_reg;
   pmonoff_pkg::pmonoff_state_t st_next;

   logic       pin_on;
   logic       want_on;
   logic       clr;
   logic       wr;
   logic       rd;
   logic [7:0] sbyte;
   logic [15:0] sword;
   logic [7:0] fmt;

   // operation field bounds, declared before the decode reads them
   localparam int OP_HI = pmonoff_pkg::OP_ACT_HI;
   localparam int OP_LO = pmonoff_pkg::OP_ACT_LO;
   localparam int MG_HI = pmonoff_pkg::OP_MRG_HI;
   localparam int MG_LO = pmonoff_pkg::OP_MRG_LO;

   // request decode
   assign wr  = req.valid && req.write;
   assign rd  = req.valid && !req.write;
   assign clr = wr && (req.code == pmonoff_pkg::CMD_CLEAR_FLT);

   // pin asserted in the configured sense
   assign pin_on = (st_reg.ctl_sync == st_reg.cfg[pmonoff_pkg::CFG_PIN_POL]);

   // on condition from pin and operation requirements
   assign want_on = (!st_reg.cfg[pmonoff_pkg::CFG_PIN_EN] || pin_on)
                 && (!st_reg.cfg[pmonoff_pkg::CFG_OP_EN] || st_reg.op_on);

   // status summary composition
   assign sbyte = {1'b0,
                   st_reg.pwr_off,
                   st_reg.flt.vout_ov,
                   st_reg.flt.iout_oc,
                   st_reg.flt.vin_uv,
                   st_reg.flt.temp,
                   st_reg.flt.cml,
                   st_reg.flt.other};
   assign sword = {st_reg.flt.vout_any,
                   st_reg.flt.iout_any,
                   st_reg.flt.input_any,
                   st_reg.flt.mfr,
                   st_reg.pgood_n,
                   3'h0,
                   sbyte};
   assign fmt   = {pmonoff_pkg::FMT_LINEAR, VOUT_EXP};

   // next-state logic
   always_comb begin
      st_next          = st_reg;
      // control pin synchroniser
      st_next.ctl_meta = ctl_pin;
      st_next.ctl_sync = st_reg.ctl_meta;

      // register writes
      if (wr && req.code == pmonoff_pkg::CMD_OPERATION) begin
         st_next.op = req.wdata[7:0];
         if (req.wdata[OP_HI:OP_LO] == pmonoff_pkg::OP_ACT_SOFT_OFF) begin
            st_next.op_on = 1'b0;
         end else if (req.wdata[OP_HI:OP_LO] == pmonoff_pkg::OP_ACT_ON
                      && req.wdata[MG_HI:MG_LO] == pmonoff_pkg::OP_MRG_NONE) begin
            st_next.op_on = 1'b1;
         end
      end else if (wr && req.code == pmonoff_pkg::CMD_ONOFF_CFG) begin
         st_next.cfg = {4'h0, req.wdata[3:0]}; // bit 0 kept, never used
      end else if (wr && req.code == pmonoff_pkg::CMD_VOUT_SET) begin
         st_next.vset = req.wdata;
      end

      // fault flags: conditions set, clear-faults clears, set wins
      if (clr) begin
         st_next.flt         = flt_cond;
         st_next.latched_off = fault_shutdown;
      end else begin
         st_next.flt         = st_reg.flt | flt_cond;
         st_next.latched_off = st_reg.latched_off | fault_shutdown;
      end
      st_next.alert = (clr ? 1'b0 : st_reg.alert) | (|flt_cond);

      // unit enable, held until operation, pin or a latched shutdown asks otherwise
      st_next.unit_en = want_on && !st_next.latched_off;
      // every turn-off runs the programmed delay and fall
      st_next.off_seq = st_reg.unit_en && !st_next.unit_en;
      st_next.pwr_off = !(st_reg.unit_en && pwr_active);
      st_next.pgood_n = !pgood;

      // command answer, one cycle after the request
      st_next.rsp.valid = req.valid;
      st_next.rsp.err   = 1'b0;
      st_next.rsp.rdata = 16'h0000;
      if (rd) begin
         if (req.code == pmonoff_pkg::CMD_OPERATION) begin
            st_next.rsp.rdata = {8'h00, st_reg.op};
         end else if (req.code == pmonoff_pkg::CMD_ONOFF_CFG) begin
            st_next.rsp.rdata = {8'h00, st_reg.cfg};
         end else if (req.code == pmonoff_pkg::CMD_VOUT_FMT) begin
            st_next.rsp.rdata = {8'h00, fmt};
         end else if (req.code == pmonoff_pkg::CMD_VOUT_SET) begin
            st_next.rsp.rdata = st_reg.vset;
         end else if (req.code == pmonoff_pkg::CMD_STAT_BYTE) begin
            st_next.rsp.rdata = {8'h00, sbyte};
         end else if (req.code == pmonoff_pkg::CMD_STAT_WORD) begin
            st_next.rsp.rdata = sword;
         end else begin
            st_next.rsp.err = 1'b1;
         end
      end else if (wr) begin
         if (req.code != pmonoff_pkg::CMD_OPERATION
             && req.code != pmonoff_pkg::CMD_ONOFF_CFG
             && req.code != pmonoff_pkg::CMD_CLEAR_FLT
             && req.code != pmonoff_pkg::CMD_VOUT_SET) begin
            st_next.rsp.err = 1'b1; // read-only or unknown code
         end
      end
      // a refused command is a communication fault
      if (st_next.rsp.err) begin
         st_next.flt.cml = 1'b1;
         st_next.alert   = 1'b1;
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg             <= '0;
         st_reg.op          <= pmonoff_pkg::OP_RESET;
         st_reg.cfg         <= pmonoff_pkg::CFG_RESET;
         st_reg.vset        <= pmonoff_pkg::VSET_RESET;
         st_reg.pwr_off     <= 1'b1;
         st_reg.pgood_n     <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state, alert_o tied low
   assign rsp           = st_reg.rsp;
   assign unit_en       = st_reg.unit_en;
   assign off_seq       = st_reg.off_seq;
   assign vout_mantissa = st_reg.vset;
   assign alert_o       = 1'b0;
   assign alert_oe      = st_reg.alert;

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence s_clear_cmd;
      req.valid && req.write && req.code == pmonoff_pkg::CMD_CLEAR_FLT;
   endsequence

   sequence s_soft_off_wr;
      req.valid && req.write && req.code == pmonoff_pkg::CMD_OPERATION
      && req.wdata[7:6] == 2'h1;
   endsequence

   sequence s_on_wr;
      req.valid && req.write && req.code == pmonoff_pkg::CMD_OPERATION
      && req.wdata[7:6] == 2'h2 && req.wdata[5:4] == 2'h0;
   endsequence

   a_soft_off_drop: assert property (
      s_soft_off_wr ##1 st_reg.cfg[3] |=> !unit_en)
      else $error("soft off write did not drop enable");

   a_pin_ignored: assert property (
      !st_reg.cfg[2]
      |=> unit_en == ((!$past(st_reg.cfg[3]) || $past(st_reg.op_on))
                      && !st_reg.latched_off))
      else $error("enable moved with pin ignored");

   a_both_needed: assert property (
      st_reg.cfg[2] && st_reg.cfg[3] && !st_reg.op_on |=> !unit_en)
      else $error("unit on without operation on");

   a_clear_flags: assert property (
      s_clear_cmd ##0 (flt_cond == '0) |=> (st_reg.flt == '0 || rsp.err))
      else $error("clear faults left a flag set");

   a_alert_free: assert property (
      s_clear_cmd ##0 (flt_cond == '0) |=> !alert_oe)
      else $error("alert held after clear faults");

   a_fault_resets: assert property (
      s_clear_cmd ##0 flt_cond.temp |=> st_reg.flt.temp ##0 sbyte[2])
      else $error("persisting fault not set again");

   a_fmt_const: assert property (
      rd && req.code == pmonoff_pkg::CMD_VOUT_FMT
      |=> rsp.valid && rsp.rdata == {8'h00, 3'h0, VOUT_EXP})
      else $error("format register value wrong");

   a_word_low: assert property (
      rd && req.code == pmonoff_pkg::CMD_STAT_WORD |=> rsp.rdata[7:0] == $past(sbyte)
      && rsp.rdata[10:8] == 3'h0 && rsp.rdata[7] == 1'b0)
      else $error("status word low byte differs");

   a_off_bit: assert property (
      !unit_en ##1 1'b1 |-> st_reg.pwr_off)
      else $error("off bit clear while disabled");

   a_pgood_bit: assert property (
      !pgood |=> sword[11])
      else $error("power-good bit not set");

   // operation register decode
   a_on_write: assert property (
      s_on_wr |=> st_reg.op_on)
      else $error("on write did not command on");

   a_soft_op: assert property (
      s_soft_off_wr |=> !st_reg.op_on)
      else $error("soft off write did not command off");

   a_op_held: assert property (
      !(req.valid && req.write && req.code == pmonoff_pkg::CMD_OPERATION)
      |=> $stable(st_reg.op_on))
      else $error("commanded mode moved without a write");

   // turn-off sequencing
   a_off_pulse: assert property (
      $fell(unit_en) |-> off_seq)
      else $error("turn-off ran without its sequence");

   a_off_only: assert property (
      off_seq |-> !unit_en && $past(unit_en))
      else $error("sequence pulse without a turn-off");

   // configuration and pin combination
   a_cfg_store: assert property (
      req.valid && req.write && req.code == pmonoff_pkg::CMD_ONOFF_CFG
      |=> st_reg.cfg[3:1] == $past(req.wdata[3:1]))
      else $error("configuration bits not stored");

   a_pin_pol: assert property (
      st_reg.cfg[2] && !st_reg.cfg[3]
      |=> unit_en == (($past(st_reg.ctl_sync) == $past(st_reg.cfg[1]))
                      && !st_reg.latched_off))
      else $error("pin polarity not applied");

   a_op_only: assert property (
      !st_reg.cfg[2] && st_reg.cfg[3]
      |=> unit_en == ($past(st_reg.op_on) && !st_reg.latched_off))
      else $error("operation requirement not applied");

   a_both_on: assert property (
      st_reg.cfg[2] && st_reg.cfg[3]
      |=> unit_en == ($past(pin_on) && $past(st_reg.op_on) && !st_reg.latched_off))
      else $error("both requirements not combined");

   // latched shutdown and its release
   a_latch_holds: assert property (
      st_reg.latched_off |-> !unit_en)
      else $error("unit on while latched off");

   a_clear_resume: assert property (
      s_clear_cmd ##0 !fault_shutdown |=> !st_reg.latched_off)
      else $error("clear faults left unit latched off");

   // sticky flags and alert
   a_flag_sticky: assert property (
      !clr |=> (st_reg.flt | $past(st_reg.flt)) == st_reg.flt)
      else $error("flag dropped without clear faults");

   a_cond_sets: assert property (
      flt_cond != '0 |=> (st_reg.flt & $past(flt_cond)) == $past(flt_cond))
      else $error("condition did not set its flag");

   a_alert_cond: assert property (
      |flt_cond |=> alert_oe)
      else $error("alert not raised by a condition");

   a_cml_on_err: assert property (
      rsp.err |-> st_reg.flt.cml)
      else $error("refused command left cml clear");

   // command answers
   a_fmt_refused: assert property (
      req.valid && req.write && req.code == pmonoff_pkg::CMD_VOUT_FMT
      |=> rsp.valid && rsp.err)
      else $error("write to format register accepted");

   a_setpoint_wr: assert property (
      req.valid && req.write && req.code == pmonoff_pkg::CMD_VOUT_SET
      |=> vout_mantissa == $past(req.wdata))
      else $error("set-point write not applied");

   a_byte_top: assert property (
      rd && req.code == pmonoff_pkg::CMD_STAT_BYTE
      |=> rsp.rdata == {8'h00, $past(sbyte)} && rsp.rdata[7] == 1'b0)
      else $error("status byte read wrong");

   a_clear_ok: assert property (
      s_clear_cmd |=> rsp.valid && !rsp.err)
      else $error("clear faults refused");

   // power summary bits
   a_on_bit_clear: assert property (
      unit_en && pwr_active |=> !st_reg.pwr_off)
      else $error("off bit set while delivering");

   a_pgood_clear: assert property (
      pgood |=> !sword[11])
      else $error("power-good bit set while good");

endmodule : pmonoff_regs

`default_nettype wire

// file: tb/pmonoff_host.sv
// host model of the command port: one command at a time, answer caught.
// assumes the block registers its answer at the edge that takes a request.
`timescale 1ns/1ps
`default_nettype none
module pmonoff_host (
   // clock
   input  wire logic                      sys_clk,
   // command port
   output var  pmonoff_pkg::pmonoff_req_t req,
   input  wire pmonoff_pkg::pmonoff_rsp_t rsp
);
   // idle until the first command
   initial req = '0;

   // raise after an edge, drop at the taking edge, then catch the answer
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output logic e, output logic [15:0] q, output logic ok);
      ok = 1'b0;
      @(posedge sys_clk);
      req <= '{valid: 1'b1, write: w, code: c, wdata: d};
      @(posedge sys_clk);
      req <= '0;
      for (int i = 0; i < 4; i++) begin
         #1;
         if (rsp.valid === 1'b1) begin
            ok = 1'b1;
            e = rsp.err;
            q = rsp.rdata;
            return;
         end
         @(posedge sys_clk);
      end
   endtask : xfer

   // clear-faults is sent as a bare command, no data
   task automatic clear_faults(output logic e, output logic [15:0] q, output logic ok);
      xfer(1'b1, pmonoff_pkg::CMD_CLEAR_FLT, 16'h0000, e, q, ok);
   endtask : clear_faults
endmodule : pmonoff_host
`default_nettype wire

// file: tb/tb_pmbus_onoff_status_regs.sv
// bench of the on/off and status command block: command table, then
// pin, fault and clear-faults cases. assumes the host model pmonoff_host.
`timescale 1ns/1ps
`default_nettype none
module tb_pmbus_onoff_status_regs;
   typedef struct packed {
      logic        w;
      logic [7:0]  code;
      logic [15:0] wdata;
      logic        err;
      logic [15:0] rdata;
   } pmonoff_row_t;
   // commands with expected error flag and read data
   localparam pmonoff_row_t ROWS [11] = '{
      '{1'b0, 8'h01, 16'h0000, 1'b0, 16'h0040}, '{1'b0, 8'h02, 16'h0000, 1'b0, 16'h000a},
      '{1'b0, 8'h20, 16'h0000, 1'b0, 16'h001d}, '{1'b1, 8'h21, 16'h1234, 1'b0, 16'h0000},
      '{1'b0, 8'h21, 16'h0000, 1'b0, 16'h1234}, '{1'b1, 8'h20, 16'h00ff, 1'b1, 16'h0000},
      '{1'b0, 8'h20, 16'h0000, 1'b0, 16'h001d}, '{1'b1, 8'h78, 16'h0000, 1'b1, 16'h0000},
      '{1'b0, 8'h55, 16'h0000, 1'b1, 16'h0000}, '{1'b0, 8'h78, 16'h0000, 1'b0, 16'h0042},
      '{1'b0, 8'h79, 16'h0000, 1'b0, 16'h0842}};
   // status word expected per condition input, lsb field first
   localparam logic [15:0] FW [10] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0020,
                                       16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h0001};
   logic                      sys_clk = 1'b0;
   logic                      arst_n = 1'b0;
   logic                      ctl_pin = 1'b0;
   logic                      fault_shutdown = 1'b0;
   logic                      pwr_active = 1'b0;
   logic                      pgood = 1'b0;
   pmonoff_pkg::pmonoff_flt_t flt_cond = '0;
   pmonoff_pkg::pmonoff_req_t req;
   pmonoff_pkg::pmonoff_rsp_t rsp;
   logic                      unit_en, off_seq, alert_o, alert_oe, e, ok;
   logic [15:0]               vout_mantissa, q;
   int                        err_count = 0;
   int                        n_checks = 0;

   // 100 ns clock
   always #50 sys_clk = ~sys_clk;

   // block under test and its host
   pmonoff_regs #(.VOUT_EXP(5'h1d)) u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .req(req),
      .rsp(rsp), .ctl_pin(ctl_pin), .flt_cond(flt_cond), .fault_shutdown(fault_shutdown),
      .pwr_active(pwr_active), .pgood(pgood), .unit_en(unit_en), .off_seq(off_seq),
      .vout_mantissa(vout_mantissa), .alert_o(alert_o), .alert_oe(alert_oe));
   pmonoff_host u_host (.sys_clk(sys_clk), .req(req), .rsp(rsp));

   task automatic tally_and_finish();
      if (err_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // one command through the host, answer compared
   task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
                      input logic ee, input logic [15:0] eq);
      if (c == pmonoff_pkg::CMD_CLEAR_FLT) u_host.clear_faults(e, q, ok);
      else u_host.xfer(w, c, d, e, q, ok);
      if (ok !== 1'b1) begin
         err_count++;
         $display("[ERR] %0t no answer to %h", $time, c);
         tally_and_finish();
      end else begin
         chk({15'h0000, e}, {15'h0000, ee}, "err flag");
         chk(q, eq, "read data");
      end
   endtask : cmd

   // bounded wait for unit_en (sel 0) or off_seq (sel 1) to reach v
   task automatic wait_en(input logic sel, input logic v);
      for (int i = 0; i < 12; i++) begin
         @(posedge sys_clk);
         #1;
         if ((sel ? off_seq : unit_en) === v) return;
      end
      chk({15'h0000, sel ? off_seq : unit_en}, {15'h0000, v}, "enable wait");
      tally_and_finish();
   endtask : wait_en

   // pin moves off the clock edges, it is asynchronous to the block
   task automatic pin(input logic v);
      #337 ctl_pin = v;
   endtask : pin

   // main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      chk({12'h000, unit_en, off_seq, alert_oe, alert_o}, 16'h0000, "reset outputs");
      chk(vout_mantissa, 16'h0000, "reset setpoint");
      arst_n <= 1'b1;
      foreach (ROWS[i]) cmd(ROWS[i].w, ROWS[i].code, ROWS[i].wdata, ROWS[i].err, ROWS[i].rdata);
      chk(vout_mantissa, 16'h1234, "setpoint out");
      chk({15'h0000, alert_oe}, 16'h0001, "alert on refusal");
      cmd(1'b1, 8'h03, 16'h0000, 1'b0, 16'h0000);
      chk({15'h0000, alert_oe}, 16'h0000, "alert released");
      cmd(1'b0, 8'h78, 16'h0000, 1'b0, 16'h0040);
      // operation register alone
      cmd(1'b1, 8'h01, 16'h0080, 1'b0, 16'h0000);
      wait_en(1'b0, 1'b1);
      pwr_active <= 1'b1;
      pgood <= 1'b1;
      repeat (3) @(posedge sys_clk);
      cmd(1'b0, 8'h79, 16'h0000, 1'b0, 16'h0000);
      cmd(1'b1, 8'h01, 16'h00c0, 1'b0, 16'h0000);
      repeat (8) @(posedge sys_clk);
      chk({15'h0000, unit_en}, 16'h0001, "mode held");
      cmd(1'b1, 8'h01, 16'h0040, 1'b0, 16'h0000);
      wait_en(1'b1, 1'b1);
      wait_en(1'b0, 1'b0);
      // control pin with both requirements, then pin alone, then neither
      cmd(1'b1, 8'h02, 16'h000f, 1'b0, 16'h0000);
      cmd(1'b1, 8'h01, 16'h0080, 1'b0, 16'h0000);
      repeat (8) @(posedge sys_clk);
      chk({15'h0000, unit_en}, 16'h0000, "pin not asserted");
      pin(1'b1);
      wait_en(1'b0, 1'b1);
      cmd(1'b1, 8'h01, 16'h0040, 1'b0, 16'h0000);
      wait_en(1'b0, 1'b0);
      cmd(1'b1, 8'h01, 16'h0080, 1'b0, 16'h0000);
      wait_en(1'b0, 1'b1);
      cmd(1'b1, 8'h02, 16'h000d, 1'b0, 16'h0000);
      wait_en(1'b0, 1'b0);
      pin(1'b0);
      wait_en(1'b0, 1'b1);
      cmd(1'b1, 8'h02, 16'h0004, 1'b0, 16'h0000);
      cmd(1'b1, 8'h01, 16'h0040, 1'b0, 16'h0000);
      repeat (8) @(posedge sys_clk);
      chk({15'h0000, unit_en}, 16'h0001, "operation ignored");
      pin(1'b1);
      wait_en(1'b0, 1'b0);
      cmd(1'b1, 8'h02, 16'h0000, 1'b0, 16'h0000);
      wait_en(1'b0, 1'b1);
      // each condition input alone, then cleared
      for (int i = 0; i < 10; i++) begin
         @(posedge sys_clk);
         flt_cond <= pmonoff_pkg::pmonoff_flt_t'(10'h001 << i);
         @(posedge sys_clk);
         flt_cond <= '0;
         cmd(1'b0, 8'h79, 16'h0000, 1'b0, FW[i]);
         chk({15'h0000, alert_oe}, 16'h0001, "alert on fault");
         cmd(1'b1, 8'h03, 16'h0000, 1'b0, 16'h0000);
         cmd(1'b0, 8'h79, 16'h0000, 1'b0, 16'h0000);
         chk({15'h0000, alert_oe}, 16'h0000, "alert after clear");
      end
      // condition still present at clear
      @(posedge sys_clk);
      flt_cond <= pmonoff_pkg::pmonoff_flt_t'(10'h080);
      cmd(1'b1, 8'h03, 16'h0000, 1'b0, 16'h0000);
      cmd(1'b0, 8'h78, 16'h0000, 1'b0, 16'h0004);
      chk({15'h0000, alert_oe}, 16'h0001, "alert kept");
      @(posedge sys_clk);
      flt_cond <= '0;
      cmd(1'b1, 8'h03, 16'h0000, 1'b0, 16'h0000);
      cmd(1'b0, 8'h78, 16'h0000, 1'b0, 16'h0000);
      // latched shutdown, resumed by clear
      @(posedge sys_clk);
      fault_shutdown <= 1'b1;
      @(posedge sys_clk);
      fault_shutdown <= 1'b0;
      wait_en(1'b0, 1'b0);
      cmd(1'b1, 8'h03, 16'h0000, 1'b0, 16'h0000);
      wait_en(1'b0, 1'b1);
      // no power delivered, power-good negated
      @(posedge sys_clk);
      pwr_active <= 1'b0;
      pgood <= 1'b0;
      repeat (3) @(posedge sys_clk);
      cmd(1'b0, 8'h79, 16'h0000, 1'b0, 16'h0840);
      // reset in mid-run puts registers back to their reset values
      @(posedge sys_clk);
      arst_n <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk({14'h0000, unit_en, alert_oe}, 16'h0000, "mid-run reset");
      chk(vout_mantissa, 16'h0000, "mid-run setpoint");
      @(posedge sys_clk);
      arst_n <= 1'b1;
      cmd(1'b0, 8'h01, 16'h0000, 1'b0, 16'h0040);
      cmd(1'b0, 8'h02, 16'h0000, 1'b0, 16'h000a);
      cmd(1'b0, 8'h21, 16'h0000, 1'b0, 16'h0000);
      tally_and_finish();
   end
endmodule : tb_pmbus_onoff_status_regs
`default_nettype wire
